// ===== design/dsp_multiply_accumulate_unit.sv
// Purpose: Multiply-accumulate datapath with two 40-bit accumulators and status.
// Assumes: The decoder issues one operation per cycle with op_valid high.
// Notes: Results and flags appear one cycle after the operation is taken.
`timescale 1ns/1ps
module dsp_multiply_accumulate_unit
    import mac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire mac_pkg::mac_op_t op_code,
    input wire logic acc_select_b,
    input wire logic [mac_pkg::OPD_W-1:0] opd_x,
    input wire logic [mac_pkg::OPD_W-1:0] opd_y,
    input wire logic x_signed,
    input wire logic y_signed,
    input wire logic fractional_mode,
    input wire logic byte_operands,
    input wire logic [mac_pkg::ACC_W-1:0] data_in,
    input wire logic shift_enable,
    input wire logic signed [mac_pkg::SHIFT_W-1:0] shift_amount,
    input wire logic zero_accum_input,
    input wire logic [mac_pkg::OPD_W-1:0] core_control_reg,
    input wire logic [mac_pkg::OPD_W-1:0] interrupt_control_one,
    output logic [mac_pkg::ACC_W-1:0] accumulator_a,
    output logic [mac_pkg::ACC_W-1:0] accumulator_b,
    output logic [mac_pkg::PROD_W-1:0] product_result,
    output logic product_valid,
    output logic guard_overflow_flag_a,
    output logic guard_overflow_flag_b,
    output logic clamped_flag_a,
    output logic clamped_flag_b,
    output logic guard_overflow_any,
    output logic clamped_any,
    output logic sign_lost_flag,
    output logic arith_warning_trap
);
    logic [MUL_W-1:0] ext_x;
    logic [MUL_W-1:0] ext_y;
    logic [PROD_W-1:0] product;
    logic [ACC_W-1:0] prod_ext;
    logic [ACC_W-1:0] scaled_data;
    logic [ACC_W-1:0] src_acc;
    logic [ACC_W-1:0] in_a;
    logic [ACC_W-1:0] in_b;
    logic carry_in;
    logic [ACC_W:0] sum;
    logic catastrophic;
    logic guard_ovf;
    logic bit31_ovf;
    logic clamp_en;
    logic true_negative;
    logic do_clamp;
    logic [ACC_W-1:0] clamped_val;
    logic uses_adder;
    logic [ACC_W-1:0] next_accumulator_a;
    logic [ACC_W-1:0] next_accumulator_b;
    logic [PROD_W-1:0] next_product_result;
    logic next_product_valid;
    logic next_guard_overflow_flag_a;
    logic next_guard_overflow_flag_b;
    logic next_clamped_flag_a;
    logic next_clamped_flag_b;
    logic next_sign_lost_flag;

    // ------------------------------------------------------------------
    // Multiplier
    // ------------------------------------------------------------------
    operand_extender u_ext_x (
        .data(opd_x),
        .is_signed(x_signed),
        .byte_size(byte_operands),
        .extended(ext_x)
    );

    operand_extender u_ext_y (
        .data(opd_y),
        .is_signed(y_signed),
        .byte_size(byte_operands),
        .extended(ext_y)
    );

    mac_multiplier u_mul (
        .opd_x(ext_x),
        .opd_y(ext_y),
        .fractional(fractional_mode),
        .product(product)
    );

    // ------------------------------------------------------------------
    // Adder operand selection
    // ------------------------------------------------------------------
    always_comb
    begin
        // Sign extension to 40 bits keeps the guard bits meaningful.
        prod_ext = {{(ACC_W-PROD_W){product[PROD_W-1]}}, product};
        // Positive amounts shift left, negative ones shift right arithmetically.
        if (!shift_enable)
        begin
            scaled_data = data_in;
        end
        else if (shift_amount[SHIFT_W-1])
        begin
            scaled_data = ACC_W'($signed(data_in) >>> (-shift_amount));
        end
        else
        begin
            scaled_data = data_in << shift_amount;
        end
        src_acc = acc_select_b ? accumulator_b : accumulator_a;
        uses_adder = op_valid && (op_code != OP_NONE) && (op_code != OP_INT_MUL);
        // Load ignores the accumulator by forcing the first input to zero.
        if (zero_accum_input || op_code == OP_LOAD)
        begin
            in_a = '0;
        end
        else
        begin
            in_a = src_acc;
        end
        unique case (op_code)
            OP_MAC_SUB:
            begin
                in_b = ~prod_ext;
                carry_in = 1'b1; // Active-low borrow: no borrow.
            end
            OP_MAC_ADD:
            begin
                in_b = prod_ext;
                carry_in = 1'b0;
            end
            default:
            begin
                in_b = scaled_data;
                carry_in = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Adder, overflow and saturation
    // ------------------------------------------------------------------
    always_comb
    begin
        sum = {1'b0, in_a} + {1'b0, in_b} + {{ACC_W{1'b0}}, carry_in};
        // Signed overflow of the 40-bit sum: the true sign is no longer held.
        catastrophic = (in_a[SIGN39] == in_b[SIGN39])
            && (sum[SIGN39] != in_a[SIGN39]);
        guard_ovf = !((&sum[SIGN39:GUARD_LO]) || !(|sum[SIGN39:GUARD_LO]))
            || catastrophic;
        bit31_ovf = guard_ovf || (sum[SIGN31] != sum[GUARD_LO]);
        clamp_en = acc_select_b ? core_control_reg[CTL_CLAMP_B]
                                : core_control_reg[CTL_CLAMP_A];
        // When the sign bit is destroyed the true sign is the opposite one.
        true_negative = catastrophic ? !sum[SIGN39] : sum[SIGN39];
        if (core_control_reg[CTL_WIDTH])
        begin
            do_clamp = clamp_en && catastrophic;
            clamped_val = true_negative ? MIN40 : MAX40;
        end
        else
        begin
            do_clamp = clamp_en && bit31_ovf;
            clamped_val = true_negative ? MIN32 : MAX32;
        end
    end

    // ------------------------------------------------------------------
    // Next state of accumulators and flags
    // ------------------------------------------------------------------
    always_comb
    begin
        next_accumulator_a = accumulator_a;
        next_accumulator_b = accumulator_b;
        next_guard_overflow_flag_a = guard_overflow_flag_a;
        next_guard_overflow_flag_b = guard_overflow_flag_b;
        next_clamped_flag_a = clamped_flag_a;
        next_clamped_flag_b = clamped_flag_b;
        next_sign_lost_flag = sign_lost_flag;
        next_product_result = product_result;
        next_product_valid = 1'b0;
        if (uses_adder)
        begin
            // Clamped flags are sticky; guard flags follow the latest operation.
            next_sign_lost_flag = catastrophic;
            if (acc_select_b)
            begin
                next_accumulator_b = do_clamp ? clamped_val : sum[ACC_W-1:0];
                next_guard_overflow_flag_b = guard_ovf;
                next_clamped_flag_b = clamped_flag_b | do_clamp;
            end
            else
            begin
                next_accumulator_a = do_clamp ? clamped_val : sum[ACC_W-1:0];
                next_guard_overflow_flag_a = guard_ovf;
                next_clamped_flag_a = clamped_flag_a | do_clamp;
            end
        end
        if (op_valid && op_code == OP_INT_MUL)
        begin
            next_product_valid = 1'b1;
            // Byte operands yield a 16-bit result in the low half.
            if (byte_operands)
            begin
                next_product_result = {{(PROD_W-OPD_W){1'b0}}, product[OPD_W-1:0]};
            end
            else
            begin
                next_product_result = product;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            accumulator_a <= ACC_RESET;
            accumulator_b <= ACC_RESET;
            product_result <= '0;
            product_valid <= 1'b0;
            guard_overflow_flag_a <= 1'b0;
            guard_overflow_flag_b <= 1'b0;
            clamped_flag_a <= 1'b0;
            clamped_flag_b <= 1'b0;
            sign_lost_flag <= 1'b0;
        end
        else
        begin
            accumulator_a <= next_accumulator_a;
            accumulator_b <= next_accumulator_b;
            product_result <= next_product_result;
            product_valid <= next_product_valid;
            guard_overflow_flag_a <= next_guard_overflow_flag_a;
            guard_overflow_flag_b <= next_guard_overflow_flag_b;
            clamped_flag_a <= next_clamped_flag_a;
            clamped_flag_b <= next_clamped_flag_b;
            sign_lost_flag <= next_sign_lost_flag;
        end
    end

    // ------------------------------------------------------------------
    // Combined status and trap
    // ------------------------------------------------------------------
    always_comb
    begin
        guard_overflow_any = guard_overflow_flag_a | guard_overflow_flag_b;
        clamped_any = clamped_flag_a | clamped_flag_b;
        arith_warning_trap =
            (guard_overflow_flag_a & interrupt_control_one[ICTL_TRAP_A])
            | (guard_overflow_flag_b & interrupt_control_one[ICTL_TRAP_B]);
    end
endmodule : dsp_multiply_accumulate_unit

// ===== common/mac_pkg.sv
// Purpose: Shared constants and types for the multiply-accumulate datapath.
// Assumes: One 40 MHz clock, asynchronous active-low reset.
// Notes: Control bit positions follow the core control and interrupt control words.
//
// Functional notes
// - Multiplier takes 17x17 operands, signed or unsigned, fractional or integer result.
// - Unsigned operands zero-extend into bit 16, signed ones sign-extend.
// - Fractional mode treats operands as Q15; product is 1.31 format.
// - Same multiplier serves signed, unsigned and mixed integer multiplies.
// - Byte multiply writes a 16-bit result, word multiply a 32-bit result.
// - 40-bit adder/subtracter with sign extension; A or B is source and destination.
// - Add and load accumulator may pre-scale data through the barrel shifter.
// - One adder input may be forced to zero, the other true or complemented.
// - Addition uses true second input and active-high carry in.
// - Subtraction complements second input and uses active-low borrow in.
// - Signed overflow of the 40-bit sum is a catastrophic overflow losing the sign.
// - Recoverable overflow when guard bits 32 to 39 are not all equal.
// - Saturation uses result, overflows, enables at bits 7:6, width select bit 4.
// - Guard-overflow flag updates on every adder pass, set by latest overflow.
// - Clamped flag sets when accumulator saturates on bit 31 or bit 39 overflow.
// - Combined flags are OR of both guard-overflow and both clamped flags.
// - Overflow and clamp indications are latched and readable as status.
// - Warning trap when guard-overflow flag and its trap enable are both set.
// - Integers are two's complement; 16-bit range 0x8000 to 0x7FFF.
package mac_pkg;
    localparam int ACC_W = 40;
    localparam int OPD_W = 16;
    localparam int MUL_W = 17;
    localparam int PROD_W = 32;
    localparam int SHIFT_W = 6;
    localparam int GUARD_LO = 32;
    localparam int SIGN31 = 31;
    localparam int SIGN39 = 39;
    // Core control word bit positions.
    localparam int CTL_CLAMP_B = 6;
    localparam int CTL_CLAMP_A = 7;
    localparam int CTL_WIDTH = 4;
    // Interrupt control word bit positions for the trap enables.
    localparam int ICTL_TRAP_A = 4;
    localparam int ICTL_TRAP_B = 3;
    localparam logic [ACC_W-1:0] MAX32 = 40'h007FFFFFFF;
    localparam logic [ACC_W-1:0] MIN32 = 40'hFF80000000;
    localparam logic [ACC_W-1:0] MAX40 = 40'h7FFFFFFFFF;
    localparam logic [ACC_W-1:0] MIN40 = 40'h8000000000;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_MAC_ADD,
        OP_MAC_SUB,
        OP_ADD_DATA,
        OP_LOAD,
        OP_INT_MUL
    } mac_op_t;
endpackage : mac_pkg

// ===== design/operand_extender.sv
// Purpose: Widens one 16-bit operand into the 17-bit multiplier input.
// Assumes: Byte operands arrive in the low eight bits.
// Notes: Used once per multiplier port.
`timescale 1ns/1ps
module operand_extender
    import mac_pkg::*;
(
    input wire logic [mac_pkg::OPD_W-1:0] data,
    input wire logic is_signed,
    input wire logic byte_size,
    output logic [mac_pkg::MUL_W-1:0] extended
);
    logic [OPD_W-1:0] word;

    always_comb
    begin
        // A byte operand is first widened to a word with the same signedness.
        if (byte_size)
        begin
            word = {{8{is_signed & data[7]}}, data[7:0]};
        end
        else
        begin
            word = data;
        end
        extended = {is_signed & word[OPD_W-1], word};
    end
endmodule : operand_extender

// ===== design/mac_multiplier.sv
// Purpose: 17x17 signed multiplier with fractional or integer scaling.
// Assumes: Operands already extended to 17 bits.
// Notes: Result is combinational; the top registers it.
`timescale 1ns/1ps
module mac_multiplier
    import mac_pkg::*;
(
    input wire logic [mac_pkg::MUL_W-1:0] opd_x,
    input wire logic [mac_pkg::MUL_W-1:0] opd_y,
    input wire logic fractional,
    output logic [mac_pkg::PROD_W-1:0] product
);
    logic signed [2*MUL_W-1:0] full;

    always_comb
    begin
        full = $signed(opd_x) * $signed(opd_y);
        // Fractional Q15 times Q15 gives Q30; one left shift aligns it to 1.31.
        if (fractional)
        begin
            product = {full[PROD_W-2:0], 1'b0};
        end
        else
        begin
            product = full[PROD_W-1:0];
        end
    end
endmodule : mac_multiplier

// ===== verif/mac_unit_checker.sv
// Purpose: Port checks for the multiply-accumulate unit.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module mac_unit_checker
    import mac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire mac_pkg::mac_op_t op_code,
    input wire logic acc_select_b,
    input wire logic shift_enable,
    input wire logic [mac_pkg::ACC_W-1:0] data_in,
    input wire logic [mac_pkg::OPD_W-1:0] core_control_reg,
    input wire logic [mac_pkg::OPD_W-1:0] interrupt_control_one,
    input wire logic [mac_pkg::ACC_W-1:0] accumulator_a,
    input wire logic [mac_pkg::ACC_W-1:0] accumulator_b,
    input wire logic product_valid,
    input wire logic guard_overflow_flag_a,
    input wire logic guard_overflow_flag_b,
    input wire logic clamped_flag_a,
    input wire logic clamped_flag_b,
    input wire logic guard_overflow_any,
    input wire logic clamped_any,
    input wire logic arith_warning_trap
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    wire logic is_mul = op_valid && (op_code == OP_INT_MUL);
    // Clamping is kept off so the loaded word must appear untouched.
    wire logic load_a = op_valid && (op_code == OP_LOAD) && !acc_select_b && !shift_enable
        && !core_control_reg[CTL_CLAMP_A];
    a_any_guard: assert property (guard_overflow_any ==
        (guard_overflow_flag_a | guard_overflow_flag_b)) else $error("Any overflow wrong.");
    a_any_clamp: assert property (clamped_any == (clamped_flag_a | clamped_flag_b))
        else $error("Any clamp wrong.");
    a_trap_cause: assert property (arith_warning_trap ==
        ((guard_overflow_flag_a & interrupt_control_one[ICTL_TRAP_A])
        | (guard_overflow_flag_b & interrupt_control_one[ICTL_TRAP_B])))
        else $error("Trap wrong.");
    a_mul_pulse: assert property (is_mul |=> product_valid)
        else $error("Product valid missing.");
    a_mul_quiet: assert property (!is_mul |=> !product_valid)
        else $error("Stray product valid.");
    a_idle_hold: assert property (!op_valid |=>
        $stable(accumulator_a) && $stable(accumulator_b)) else $error("Idle change.");
    a_other_hold: assert property (op_valid && acc_select_b |=> $stable(accumulator_a))
        else $error("Unselected accumulator moved.");
    a_load_plain: assert property (load_a |=> accumulator_a == $past(data_in))
        else $error("Load value wrong.");
    a_clamp_sticky: assert property (!$fell(clamped_flag_a) && !$fell(clamped_flag_b))
        else $error("Clamp flag cleared.");
    a_guard_cause: assert property ($changed(guard_overflow_flag_a)
        |-> $past(op_valid)) else $error("Guard flag moved while idle.");
    c_trap: cover property (arith_warning_trap);
    c_clamp_b: cover property (clamped_flag_b);
    c_mul: cover property (product_valid);
endmodule : mac_unit_checker

bind dsp_multiply_accumulate_unit mac_unit_checker i_checker (.*);

// ===== verif/core_decoder_model.sv
// Purpose: Decoder model that issues operations and operands to the datapath.
// Assumes: Every change happens at the falling edge.
// Notes: Released operand and data lines are inverted, as a real bus keeps no last value.
`timescale 1ns/1ps
module core_decoder_model
    import mac_pkg::*;
(
    input wire logic ref_clk,
    output logic op_valid,
    output mac_pkg::mac_op_t op_code,
    output logic acc_select_b,
    output logic [mac_pkg::OPD_W-1:0] opd_x,
    output logic [mac_pkg::OPD_W-1:0] opd_y,
    output logic x_signed,
    output logic y_signed,
    output logic fractional_mode,
    output logic byte_operands,
    output logic [mac_pkg::ACC_W-1:0] data_in
);
    initial
    begin
        op_code = OP_NONE;
        {op_valid, acc_select_b, opd_x, opd_y, x_signed, y_signed} = '0;
        {fractional_mode, byte_operands, data_in} = '0;
    end

    // Mode bits are packed as signed x, signed y, fractional, byte.
    task automatic setm(input logic [OPD_W-1:0] x, input logic [OPD_W-1:0] y, input logic [3:0] m);
        {opd_x, opd_y, x_signed, y_signed, fractional_mode, byte_operands} = {x, y, m};
    endtask : setm

    // Back-to-back calls keep valid high, one operation per rising edge.
    task automatic issue(input mac_op_t op, input logic sel, input logic [ACC_W-1:0] d);
        op_code = op;
        {op_valid, acc_select_b, data_in} = {1'h1, sel, d};
        @(negedge ref_clk);
    endtask : issue

    task automatic idle();
        op_valid = 1'h0;
        op_code = OP_NONE;
        {opd_x, opd_y, data_in} = ~{opd_x, opd_y, data_in};
        @(negedge ref_clk);
    endtask : idle
endmodule : core_decoder_model

// ===== verif/dsp_multiply_accumulate_unit_bench.sv
// Purpose: Self-checking bench for the multiply-accumulate unit.
// Assumes: Results are read at the falling edge after the taking edge.
// Notes: Expected values are worked out by hand from the arithmetic.
`timescale 1ns/1ps
module dsp_multiply_accumulate_unit_bench;
    import mac_pkg::*;
    logic ref_clk = 1'h0;
    logic arst_n = 1'h0;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic op_valid, acc_select_b, x_signed, y_signed, fractional_mode, byte_operands;
    logic product_valid, guard_overflow_flag_a, guard_overflow_flag_b, clamped_flag_a;
    logic clamped_flag_b, guard_overflow_any, clamped_any, sign_lost_flag, arith_warning_trap;
    logic shift_enable = 1'h0;
    logic zero_accum_input = 1'h0;
    logic signed [SHIFT_W-1:0] shift_amount = 6'h00;
    logic [OPD_W-1:0] core_control_reg = 16'h0000;
    logic [OPD_W-1:0] interrupt_control_one = 16'h0000;
    logic [OPD_W-1:0] opd_x, opd_y;
    logic [ACC_W-1:0] data_in, accumulator_a, accumulator_b;
    logic [PROD_W-1:0] product_result;
    mac_op_t op_code;

    core_decoder_model i_core (.*);
    dsp_multiply_accumulate_unit i_dut (.*);

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input string n, input logic [ACC_W-1:0] s, input logic [ACC_W-1:0] e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic mcase(input logic [15:0] x, input logic [15:0] y, input logic [3:0] m,
        input logic [PROD_W-1:0] e);
        i_core.setm(x, y, m);
        i_core.issue(OP_INT_MUL, 1'h0, 40'h0000000000);
        chk("product_result", product_result, e);
        chk("product_valid", product_valid, 1'h1);
    endtask : mcase

    task automatic t_mul();
        mcase(16'hFFFF, 16'hFFFF, 4'h0, 32'hFFFE0001);
        mcase(16'hFFFF, 16'hFFFF, 4'hC, 32'h00000001);
        mcase(16'hFFFF, 16'h0002, 4'h8, 32'hFFFFFFFE);
        mcase(16'h8000, 16'h7FFF, 4'hC, 32'hC0008000);
        mcase(16'h4000, 16'h4000, 4'hE, 32'h20000000);
        mcase(16'hABFF, 16'h12FF, 4'h1, 32'h0000FE01);
        mcase(16'h12FF, 16'h3402, 4'h9, 32'h0000FFFE);
        i_core.idle();
        chk("product_valid", product_valid, 1'h0);
        $display("test multiply done");
    endtask : t_mul

    task automatic t_acc();
        i_core.setm(16'h0003, 16'h0004, 4'hC);
        i_core.issue(OP_LOAD, 1'h1, 40'h0000000010);
        i_core.issue(OP_MAC_ADD, 1'h1, 40'h0000000000);
        chk("accumulator_b", accumulator_b, 40'h000000001C);
        i_core.issue(OP_MAC_SUB, 1'h1, 40'h0000000000);
        i_core.idle();
        chk("accumulator_b", accumulator_b, 40'h0000000010);
        chk("accumulator_a", accumulator_a, 40'h0000000000);
        $display("test accumulate done");
    endtask : t_acc

    task automatic t_shift();
        shift_enable = 1'h1;
        shift_amount = 6'h04;
        i_core.issue(OP_LOAD, 1'h0, 40'h0000000001);
        chk("accumulator_a", accumulator_a, 40'h0000000010);
        shift_amount = 6'h3F;
        i_core.issue(OP_ADD_DATA, 1'h0, 40'hFFFFFFFFFE);
        chk("accumulator_a", accumulator_a, 40'h000000000F);
        shift_enable = 1'h0;
        zero_accum_input = 1'h1;
        i_core.issue(OP_ADD_DATA, 1'h0, 40'h0000000005);
        i_core.idle();
        zero_accum_input = 1'h0;
        chk("accumulator_a", accumulator_a, 40'h0000000005);
        i_core.issue(OP_NONE, 1'h0, 40'h0000000007);
        chk("accumulator_a", accumulator_a, 40'h0000000005);
        $display("test shift done");
    endtask : t_shift

    task automatic t_guard();
        interrupt_control_one = 16'h0010;
        i_core.issue(OP_LOAD, 1'h0, 40'h00FFFFFFFF);
        i_core.issue(OP_ADD_DATA, 1'h0, 40'h0000000001);
        chk("accumulator_a", accumulator_a, 40'h0100000000);
        chk("guard_overflow_flag_a", guard_overflow_flag_a, 1'h1);
        chk("guard_overflow_any", guard_overflow_any, 1'h1);
        chk("arith_warning_trap", arith_warning_trap, 1'h1);
        interrupt_control_one = 16'h0008;
        i_core.idle();
        chk("arith_warning_trap", arith_warning_trap, 1'h0);
        i_core.issue(OP_LOAD, 1'h0, 40'h0000000005);
        i_core.idle();
        chk("ovf any", {guard_overflow_flag_a, guard_overflow_any}, 2'h0);
        $display("test guard done");
    endtask : t_guard

    task automatic t_clamp();
        core_control_reg = 16'h0080;
        interrupt_control_one = 16'h0008;
        i_core.issue(OP_LOAD, 1'h0, 40'h007FFFFFFF);
        i_core.issue(OP_ADD_DATA, 1'h0, 40'h0000000001);
        chk("accumulator_a", accumulator_a, MAX32);
        chk("clamp any", {clamped_flag_a, clamped_any}, 2'h3);
        zero_accum_input = 1'h1;
        i_core.issue(OP_ADD_DATA, 1'h0, 40'hFF00000000);
        chk("accumulator_a", accumulator_a, MIN32);
        zero_accum_input = 1'h0;
        core_control_reg = 16'h0050;
        i_core.issue(OP_LOAD, 1'h1, MAX40);
        i_core.issue(OP_ADD_DATA, 1'h1, 40'h0000000001);
        chk("accumulator_b", accumulator_b, MAX40);
        chk("sign_lost_flag", sign_lost_flag, 1'h1);
        chk("clamp flags", {clamped_flag_b, clamped_flag_a}, 2'h3);
        chk("guard_overflow_flag_b", guard_overflow_flag_b, 1'h1);
        chk("arith_warning_trap", arith_warning_trap, 1'h1);
        core_control_reg = 16'h0000;
        i_core.issue(OP_LOAD, 1'h1, MAX40);
        i_core.issue(OP_ADD_DATA, 1'h1, 40'h0000000001);
        i_core.idle();
        chk("accumulator_b", accumulator_b, MIN40);
        chk("sign_lost_flag", sign_lost_flag, 1'h1);
        $display("test clamp done");
    endtask : t_clamp

    // A hang would otherwise stall the run silently.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (16) @(negedge ref_clk);
        arst_n = 1'h1;
        t_acc();
        t_mul();
        t_shift();
        t_guard();
        t_clamp();
        tally_and_finish();
    end
endmodule : dsp_multiply_accumulate_unit_bench
